//--- hw/arm_pkg.sv
// Constants, register map and types for the range/mode/channel block
package arm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS       = 8'h01;
  localparam logic [7:0] ADDR_SEQ          = 8'h02;
  localparam logic [7:0] ADDR_CHAN         = 8'h03;
  localparam logic [7:0] ADDR_RANGE0       = 8'h04;
  localparam logic [7:0] ADDR_RANGE3       = 8'h07;
  localparam logic [7:0] ADDR_OVR_A_FIRST  = 8'h08;
  localparam logic [7:0] ADDR_OVR_B_FIRST  = 8'h09;
  localparam logic [7:0] ADDR_OVR_A_SECOND = 8'h0A;
  localparam logic [7:0] ADDR_OVR_B_SECOND = 8'h0B;

  // Values after reset
  localparam logic [7:0] RST_RANGE = 8'hFF;
  localparam logic [7:0] RST_OVR   = 8'h00;
  localparam logic [7:0] RST_CHAN  = 8'h00;
  localparam logic [7:0] RST_SEQ   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Range codes, shared by the pins and the range registers
  localparam logic [1:0] RANGE_SW  = 2'h0;
  localparam logic [1:0] RANGE_2V5 = 2'h1;
  localparam logic [1:0] RANGE_5V  = 2'h2;
  localparam logic [1:0] RANGE_10V = 2'h3;

  // Channel select codes
  localparam int         SEL_W      = 4;
  localparam logic [3:0] SEL_SUPPLY = 4'h8;
  localparam logic [3:0] SEL_LDO    = 4'h9;

  // Field positions
  localparam int CHAN_A_LSB        = 0;
  localparam int CHAN_B_LSB        = 4;
  localparam int SEQ_EN_BIT        = 0;
  localparam int SEQ_LAST_LSB      = 4;
  localparam int STAT_HW_BIT       = 0;
  localparam int STAT_SETTLE_BIT   = 1;
  localparam int STAT_SEQ_BIT      = 2;
  localparam int STAT_MISMATCH_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: settle time rounds up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_US     = 120;
  localparam int SETTLE_CYCLES =
    (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Pair selector states
  typedef enum logic {SEL_LOAD, SEL_RUN} arm_sel_state_type;

endpackage : arm_pkg

//--- hw/arm_sel_if.sv
// Interface between the top and the channel pair selector
`timescale 1ns/10ps
interface arm_sel_if
  import arm_pkg::*;
();
  logic             hw_mode;
  logic             conv_start;
  logic             seq_on;
  logic [2:0]       pick_bus;
  logic [2:0]       seq_last;
  logic [SEL_W-1:0] reg_sel_a;
  logic [SEL_W-1:0] reg_sel_b;
  logic [SEL_W-1:0] sel_a;
  logic [SEL_W-1:0] sel_b;

  modport ctrl (
    output hw_mode, conv_start, seq_on, pick_bus, seq_last,
    output reg_sel_a, reg_sel_b,
    input  sel_a, sel_b
  );
  modport sel (
    input  hw_mode, conv_start, seq_on, pick_bus, seq_last,
    input  reg_sel_a, reg_sel_b,
    output sel_a, sel_b
  );
endinterface : arm_sel_if

//--- hw/arm_chan_cfg.sv
// Per-channel effective range and overrange decode
`timescale 1ns/10ps
module arm_chan_cfg
  import arm_pkg::*;
#(
  parameter int CODE_W = 2
)
(
  input  wire logic              hw_mode,
  input  wire logic [CODE_W-1:0] pin_code,
  input  wire logic [CODE_W-1:0] reg_code,
  input  wire logic              ovr_first,
  input  wire logic              ovr_second,
  output logic      [CODE_W-1:0] range_code,
  output logic                   over_en,
  output logic                   pair_mismatch
);

  // Pins in hardware mode, register otherwise; empty code reads as 10 V
  assign range_code = hw_mode ? pin_code :
    ((reg_code == CODE_W'(RANGE_SW)) ? CODE_W'(RANGE_10V) : reg_code);

  // Overrange only in software mode and only with both copies set
  assign over_en = !hw_mode && ovr_first && ovr_second;

  // Copies disagree
  assign pair_mismatch = ovr_first ^ ovr_second;

endmodule : arm_chan_cfg

//--- hw/arm_pair_sel.sv
// Channel pair selector with initial capture and scan sequencer
`timescale 1ns/10ps
module arm_pair_sel
  import arm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  arm_sel_if.sel    sel_bus
);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  arm_sel_state_type state_reg;
  arm_sel_state_type state_next;
  logic [SEL_W-1:0]  sel_a_reg;
  logic [SEL_W-1:0]  sel_a_next;
  logic [SEL_W-1:0]  sel_b_reg;
  logic [SEL_W-1:0]  sel_b_next;
  logic [2:0]        idx_reg;
  logic [2:0]        idx_next;
  logic              take;

  ////////////////////////////////////////////////////////////////////////////
  // First cycle after release, then once per conversion
  assign take = (state_reg == SEL_LOAD) || sel_bus.conv_start;

  // Next selection
  always_comb
  begin
    state_next = state_reg;
    sel_a_next = sel_a_reg;
    sel_b_next = sel_b_reg;
    idx_next   = sel_bus.seq_on ? idx_reg : 3'h0;
    case (state_reg)
      SEL_LOAD: state_next = SEL_RUN;
      SEL_RUN:  state_next = SEL_RUN;
      default:  state_next = SEL_LOAD;
    endcase
    if (take)
    begin
      if (sel_bus.seq_on)
      begin
        sel_a_next = {1'b0, idx_reg};
        sel_b_next = {1'b0, idx_reg};
        idx_next   = (idx_reg == sel_bus.seq_last) ? 3'h0 : idx_reg + 3'h1;
      end
      else if (sel_bus.hw_mode)
      begin
        sel_a_next = {1'b0, sel_bus.pick_bus};
        sel_b_next = {1'b0, sel_bus.pick_bus};
      end
      else
      begin
        if (sel_bus.reg_sel_a <= SEL_LDO)
          sel_a_next = sel_bus.reg_sel_a;
        if (sel_bus.reg_sel_b <= SEL_LDO)
          sel_b_next = sel_bus.reg_sel_b;
      end
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= SEL_LOAD;
      sel_a_reg <= 4'h0;
      sel_b_reg <= 4'h0;
      idx_reg   <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      sel_a_reg <= sel_a_next;
      sel_b_reg <= sel_b_next;
      idx_reg   <= idx_next;
    end
  end

  assign sel_bus.sel_a = sel_a_reg;
  assign sel_bus.sel_b = sel_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_FIRST_PAIR: assert property (
    (state_reg == SEL_LOAD && sel_bus.hw_mode && !sel_bus.seq_on) |=>
      sel_a_reg == {1'b0, $past(sel_bus.pick_bus)})
    else $error("first pair not taken from pick pins");

  AST_HW_PAIR: assert property (
    (sel_bus.hw_mode && !sel_bus.seq_on && take) |=>
      (sel_a_reg == {1'b0, $past(sel_bus.pick_bus)}) &&
      (sel_b_reg == sel_a_reg))
    else $error("hardware pair not matched");

  AST_HW_NO_DIAG: assert property (
    (sel_bus.hw_mode && take) |=> !sel_a_reg[3] && !sel_b_reg[3])
    else $error("diagnostic channel in hardware mode");

  AST_SW_ANY: assert property (
    (!sel_bus.hw_mode && !sel_bus.seq_on && take &&
     sel_bus.reg_sel_a <= SEL_LDO && sel_bus.reg_sel_b <= SEL_LDO) |=>
      sel_a_reg == $past(sel_bus.reg_sel_a) &&
      sel_b_reg == $past(sel_bus.reg_sel_b))
    else $error("software pair not applied");

  AST_SEQ_WRAP: assert property (
    (sel_bus.seq_on && take && idx_reg == sel_bus.seq_last) |=>
      idx_reg == 3'h0)
    else $error("sequencer did not wrap");

endmodule : arm_pair_sel

//--- hw/arm_config.sv
// Top of the range, mode and channel configuration block
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module arm_config
  import arm_pkg::*;
#(
  parameter int P_SETTLE_CYCLES = SETTLE_CYCLES
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [1:0]        range_pins,
  input  wire logic [2:0]        channel_pick_bus,
  input  wire logic              seq_pin,
  input  wire logic              filter_option_two,
  input  wire logic              conv_start,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   hw_mode,
  output logic      [15:0]       range_a,
  output logic      [15:0]       range_b,
  output logic      [7:0]        over_a,
  output logic      [7:0]        over_b,
  output logic      [SEL_W-1:0]  sel_a,
  output logic      [SEL_W-1:0]  sel_b,
  output logic                   settle_pending
);

  localparam int CNT_W = $clog2(P_SETTLE_CYCLES + 1);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]        seq_reg;
  logic [7:0]        seq_next;
  logic [7:0]        chan_reg;
  logic [7:0]        chan_next;
  logic [7:0]        range_reg [4];
  logic [7:0]        range_next [4];
  logic [7:0]        ovr_a_first_reg;
  logic [7:0]        ovr_a_first_next;
  logic [7:0]        ovr_b_first_reg;
  logic [7:0]        ovr_b_first_next;
  logic [7:0]        ovr_a_second_reg;
  logic [7:0]        ovr_a_second_next;
  logic [7:0]        ovr_b_second_reg;
  logic [7:0]        ovr_b_second_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] status_word;
  logic              hw_mode_reg;
  logic              hw_mode_next;
  logic [31:0]       cfg_range_reg;
  logic [31:0]       cfg_range_next;
  logic [15:0]       cfg_over_reg;
  logic [15:0]       cfg_over_next;
  logic [1:0]        pins_prev_reg;
  logic [1:0]        pins_prev_next;
  logic [CNT_W-1:0]  settle_cnt_reg;
  logic [CNT_W-1:0]  settle_cnt_next;
  logic              settle_reg;
  logic              settle_next;
  logic              hw_now;
  logic              seq_on;
  logic              settle_trig;
  logic [31:0]       reg_codes;
  logic [15:0]       ovr_first_all;
  logic [15:0]       ovr_second_all;
  logic [15:0]       mismatch_all;

  arm_sel_if sel_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Mode from the range pins
  assign hw_now = (range_pins != RANGE_SW);
  assign seq_on = hw_now ? seq_pin : seq_reg[SEQ_EN_BIT];

  // Register writes
  always_comb
  begin
    seq_next          = seq_reg;
    chan_next         = chan_reg;
    range_next        = range_reg;
    ovr_a_first_next  = ovr_a_first_reg;
    ovr_b_first_next  = ovr_b_first_reg;
    ovr_a_second_next = ovr_a_second_reg;
    ovr_b_second_next = ovr_b_second_reg;
    if (reg_wr)
    begin
      if (reg_addr == ADDR_SEQ)
        seq_next = reg_wdata;
      else if (reg_addr == ADDR_CHAN)
        chan_next = reg_wdata;
      else if (reg_addr >= ADDR_RANGE0 && reg_addr <= ADDR_RANGE3)
        range_next[reg_addr[1:0]] = reg_wdata;
      else if (reg_addr == ADDR_OVR_A_FIRST)
        ovr_a_first_next = reg_wdata;
      else if (reg_addr == ADDR_OVR_B_FIRST)
        ovr_b_first_next = reg_wdata;
      else if (reg_addr == ADDR_OVR_A_SECOND)
        ovr_a_second_next = reg_wdata;
      else if (reg_addr == ADDR_OVR_B_SECOND)
        ovr_b_second_next = reg_wdata;
    end
  end

  // Status word
  always_comb
  begin
    status_word                    = 8'h00;
    status_word[STAT_HW_BIT]       = hw_mode_reg;
    status_word[STAT_SETTLE_BIT]   = settle_reg;
    status_word[STAT_SEQ_BIT]      = seq_on;
    status_word[STAT_MISMATCH_BIT] = |mismatch_all;
  end

  // Register reads, unmapped offsets read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd)
    begin
      if (reg_addr == ADDR_STATUS)
        rdata_next = status_word;
      else if (reg_addr == ADDR_SEQ)
        rdata_next = seq_reg;
      else if (reg_addr == ADDR_CHAN)
        rdata_next = chan_reg;
      else if (reg_addr >= ADDR_RANGE0 && reg_addr <= ADDR_RANGE3)
        rdata_next = range_reg[reg_addr[1:0]];
      else if (reg_addr == ADDR_OVR_A_FIRST)
        rdata_next = ovr_a_first_reg;
      else if (reg_addr == ADDR_OVR_B_FIRST)
        rdata_next = ovr_b_first_reg;
      else if (reg_addr == ADDR_OVR_A_SECOND)
        rdata_next = ovr_a_second_reg;
      else if (reg_addr == ADDR_OVR_B_SECOND)
        rdata_next = ovr_b_second_reg;
      else
        rdata_next = 8'h00;
    end
  end

  // Register file
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seq_reg          <= RST_SEQ;
      chan_reg         <= RST_CHAN;
      range_reg        <= '{RST_RANGE, RST_RANGE, RST_RANGE, RST_RANGE};
      ovr_a_first_reg  <= RST_OVR;
      ovr_b_first_reg  <= RST_OVR;
      ovr_a_second_reg <= RST_OVR;
      ovr_b_second_reg <= RST_OVR;
      rdata_reg        <= 8'h00;
    end
    else
    begin
      seq_reg          <= seq_next;
      chan_reg         <= chan_next;
      range_reg        <= range_next;
      ovr_a_first_reg  <= ovr_a_first_next;
      ovr_b_first_reg  <= ovr_b_first_next;
      ovr_a_second_reg <= ovr_a_second_next;
      ovr_b_second_reg <= ovr_b_second_next;
      rdata_reg        <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel range and overrange, A0..A7 then B0..B7
  assign reg_codes      = {range_reg[3], range_reg[2],
                           range_reg[1], range_reg[0]};
  assign ovr_first_all  = {ovr_b_first_reg, ovr_a_first_reg};
  assign ovr_second_all = {ovr_b_second_reg, ovr_a_second_reg};

  for (genvar i = 0; i < 16; i++)
  begin : g_chan
    arm_chan_cfg #(
      .CODE_W        (2)
    ) u_chan (
      .hw_mode       (hw_now),
      .pin_code      (range_pins),
      .reg_code      (reg_codes[2*i +: 2]),
      .ovr_first     (ovr_first_all[i]),
      .ovr_second    (ovr_second_all[i]),
      .range_code    (cfg_range_next[2*i +: 2]),
      .over_en       (cfg_over_next[i]),
      .pair_mismatch (mismatch_all[i])
    );
  end

  // Settle timer restarts on every pin change to a hardware range (not to 00) with filter 2
  assign settle_trig = hw_now && filter_option_two &&
                       (range_pins != pins_prev_reg);

  always_comb
  begin
    hw_mode_next    = hw_now;
    pins_prev_next  = range_pins;
    settle_cnt_next = settle_cnt_reg;
    if (settle_trig)
      settle_cnt_next = CNT_W'(P_SETTLE_CYCLES);
    else if (settle_cnt_reg != '0)
      settle_cnt_next = settle_cnt_reg - CNT_W'(1);
    settle_next = (settle_cnt_next != '0);
  end

  // Configuration outputs and settle state
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hw_mode_reg    <= 1'b0;
      cfg_range_reg  <= '0;
      cfg_over_reg   <= '0;
      pins_prev_reg  <= RANGE_SW;
      settle_cnt_reg <= '0;
      settle_reg     <= 1'b0;
    end
    else
    begin
      hw_mode_reg    <= hw_mode_next;
      cfg_range_reg  <= cfg_range_next;
      cfg_over_reg   <= cfg_over_next;
      pins_prev_reg  <= pins_prev_next;
      settle_cnt_reg <= settle_cnt_next;
      settle_reg     <= settle_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel pair selection
  assign sel_bus.hw_mode    = hw_now;
  assign sel_bus.conv_start = conv_start;
  assign sel_bus.seq_on     = seq_on;
  assign sel_bus.pick_bus   = channel_pick_bus;
  assign sel_bus.seq_last   = hw_now ? 3'h7 : seq_reg[SEQ_LAST_LSB +: 3];
  assign sel_bus.reg_sel_a  = chan_reg[CHAN_A_LSB +: SEL_W];
  assign sel_bus.reg_sel_b  = chan_reg[CHAN_B_LSB +: SEL_W];

  arm_pair_sel u_pair_sel (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .sel_bus (sel_bus)
  );

  // Outputs
  assign reg_rdata      = rdata_reg;
  assign hw_mode        = hw_mode_reg;
  assign range_a        = cfg_range_reg[15:0];
  assign range_b        = cfg_range_reg[31:16];
  assign over_a         = cfg_over_reg[7:0];
  assign over_b         = cfg_over_reg[15:8];
  assign sel_a          = sel_bus.sel_a;
  assign sel_b          = sel_bus.sel_b;
  assign settle_pending = settle_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence settle_start_s;
    settle_trig;
  endsequence

  sequence settle_hold_s;
    settle_pending [*8];
  endsequence

  AST_HW_MODE: assert property (
    (range_pins != RANGE_SW) |=> hw_mode)
    else $error("hardware mode not entered");

  AST_SW_MODE: assert property (
    (range_pins == RANGE_SW) |=> !hw_mode)
    else $error("software mode not entered");

  AST_PIN_ALL: assert property (
    (range_pins != RANGE_SW) |=>
      range_a == {8{$past(range_pins)}} && range_b == {8{$past(range_pins)}})
    else $error("pin range not on every channel");

  AST_PIN_5V: assert property (
    (range_pins == RANGE_5V) |=> range_b[15:14] == 2'h2)
    else $error("5 V pin code misdecoded");

  AST_SW_RANGE: assert property (
    (range_pins == RANGE_SW && range_reg[2][3:2] != RANGE_SW) |=>
      range_b[3:2] == $past(range_reg[2][3:2]))
    else $error("channel range register not applied");

  AST_HW_NO_OVR: assert property (
    (range_pins != RANGE_SW) |=> over_a == 8'h00 && over_b == 8'h00)
    else $error("overrange active in hardware mode");

  AST_OVR_PAIR: assert property (
    (range_pins == RANGE_SW) |=>
      over_a[5] == $past(ovr_a_first_reg[5] && ovr_a_second_reg[5]))
    else $error("overrange not gated by both copies");

  AST_OVR_WRITE: assert property (
    (reg_wr && reg_addr == ADDR_OVR_B_FIRST && range_pins == RANGE_SW &&
     ovr_b_second_reg[0] && reg_wdata[0]) ##1 (range_pins == RANGE_SW)
      |=> over_b[0])
    else $error("written overrange not applied");

  AST_SETTLE: assert property (
    settle_start_s |=> settle_hold_s)
    else $error("settle flag dropped early");

  AST_OVR_SPLIT: assert property (
    (range_pins == RANGE_SW && (ovr_a_first_reg[4] != ovr_a_second_reg[4]))
      |=> !over_a[4])
    else $error("overrange applied with split copies");

  AST_RDATA_HOLD: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

endmodule : arm_config

//--- tb/arm_host.sv
// Host controller model driving the register port
`timescale 1ns/10ps
module arm_host
  import arm_pkg::*;
(
  input  wire logic              ref_clk,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata
);
  // Idle port at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One write strobe; bus scrambled once released
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
    @(posedge ref_clk);
    #1;
  endtask : wr

  // One read strobe; data registered at the taking edge
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~addr;
    data     = reg_rdata;
    @(posedge ref_clk);
    #1;
  endtask : rd

  // Overrange mask into both copies of one group
  task automatic ovr_set(input logic grp, input logic [7:0] first,
                         input logic [7:0] second);
    wr(grp ? ADDR_OVR_B_FIRST : ADDR_OVR_A_FIRST, first);
    wr(grp ? ADDR_OVR_B_SECOND : ADDR_OVR_A_SECOND, second);
  endtask : ovr_set
endmodule : arm_host

//--- tb/arm_config_tb.sv
// Self-checking testbench for the configuration block
`timescale 1ns/10ps
module arm_config_tb import arm_pkg::*;;
  localparam int SETTLE_SIM = 16;
  logic              ref_clk = 1'b0;
  logic              rst_b, seq_pin, filter_option_two, conv_start;
  logic [1:0]        range_pins;
  logic [2:0]        channel_pick_bus;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val, m;
  logic              reg_wr, reg_rd, hw_mode, settle_pending;
  logic [15:0]       range_a, range_b;
  logic [7:0]        over_a, over_b;
  logic [SEL_W-1:0]  sel_a, sel_b, prev;
  int                err_count = 0;
  int                tests_run = 0;
  int                rng[4];
  int                seen_cnt;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  arm_config #(.P_SETTLE_CYCLES(SETTLE_SIM)) arm_config_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .range_pins(range_pins),
    .channel_pick_bus(channel_pick_bus), .seq_pin(seq_pin),
    .filter_option_two(filter_option_two), .conv_start(conv_start),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_mode(hw_mode),
    .range_a(range_a), .range_b(range_b), .over_a(over_a),
    .over_b(over_b), .sel_a(sel_a), .sel_b(sel_b),
    .settle_pending(settle_pending));

  arm_host arm_host_inst (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Range register byte as applied: code 00 acts as 10 V
  function automatic logic [7:0] eff(input int code8);
    logic [7:0] r;
    r = code8[7:0];
    for (int k = 0; k < 4; k++)
      if (r[2*k+:2] == 2'h0)
        r[2*k+:2] = RANGE_10V;
    return r;
  endfunction : eff

  // Wait edges, land just after the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // One conversion start pulse, then a quiet edge
  task automatic conv();
    conv_start = 1'b1;
    @(posedge ref_clk);
    #1;
    conv_start = 1'b0;
    cyc(1);
  endtask : conv

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    range_pins = 2'h0;
    channel_pick_bus = 3'h0;
    seq_pin = 1'b0;
    filter_option_two = 1'b0;
    conv_start = 1'b0;
    void'($urandom(36));
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    cyc(2);
    check("hw_mode", hw_mode, 1'b0);
    check("range_a", range_a, {eff(RST_RANGE), eff(RST_RANGE)});
    arm_host_inst.rd(ADDR_RANGE0, rd_val);
    check("range0 reset", rd_val, RST_RANGE);
    arm_host_inst.rd(ADDR_OVR_A_FIRST, rd_val);
    check("ovr reset", rd_val, RST_OVR);
    arm_host_inst.rd(8'h20, rd_val);
    check("unmapped", rd_val, 8'h00);
    $display("Reset test done");
    // Pin-selected ranges in hardware mode
    for (int c = 1; c < 4; c++)
    begin
      range_pins = c[1:0];
      cyc(2);
      check("hw_mode", hw_mode, 1'b1);
      check("range_a", range_a, {8{c[1:0]}});
      check("range_b", range_b, {8{c[1:0]}});
    end
    $display("Hardware range test done");
    // Per-channel ranges in software mode
    range_pins = 2'h0;
    for (int r = 0; r < 4; r++)
    begin
      rng[r] = $urandom & 32'hFC;
      arm_host_inst.wr(ADDR_RANGE0 + 8'(r), rng[r][7:0]);
    end
    cyc(1);
    check("range_a", range_a, {eff(rng[1]), eff(rng[0])});
    check("range_b", range_b, {eff(rng[3]), eff(rng[2])});
    arm_host_inst.rd(ADDR_RANGE3, rd_val);
    check("range3 readback", rd_val, rng[3][7:0]);
    $display("Software range test done");
    // Overrange with mismatching and matching copies
    for (int g = 0; g < 2; g++)
    begin
      m = 8'($urandom) | 8'h11;
      arm_host_inst.ovr_set(g[0], m, m ^ 8'h10);
      cyc(1);
      check("over", g ? over_b : over_a, m & ~8'h10);
      arm_host_inst.rd(ADDR_STATUS, rd_val);
      check("status mismatch", rd_val, 8'h08);
      arm_host_inst.ovr_set(g[0], m, m);
      cyc(1);
      check("over", g ? over_b : over_a, m);
    end
    range_pins = 2'h2;
    cyc(2);
    check("over_a", over_a, 8'h00);
    check("over_b", over_b, 8'h00);
    $display("Overrange test done");
    // Pin-picked pairs in hardware mode
    for (int i = 0; i < 4; i++)
    begin
      channel_pick_bus = 3'($urandom);
      conv();
      check("sel_a", sel_a, {1'b0, channel_pick_bus});
      check("sel_b", sel_b, {1'b0, channel_pick_bus});
    end
    // Sequencer scan with wrap after pair seven
    seq_pin = 1'b1;
    conv();
    prev = 4'h0;
    check("seq first", sel_a, prev);
    for (int i = 0; i < 9; i++)
    begin
      conv();
      prev = (prev == 4'h7) ? 4'h0 : prev + 4'h1;
      check("seq sel_a", sel_a, prev);
      check("seq sel_b", sel_b, prev);
    end
    seq_pin = 1'b0;
    $display("Hardware select test done");
    // Register-picked pairs in software mode
    range_pins = 2'h0;
    arm_host_inst.wr(ADDR_CHAN, 8'h38);
    conv();
    check("sel_a", sel_a, SEL_SUPPLY);
    check("sel_b", sel_b, 4'h3);
    arm_host_inst.wr(ADDR_CHAN, 8'h9C);
    conv();
    check("sel_a kept", sel_a, SEL_SUPPLY);
    check("sel_b", sel_b, SEL_LDO);
    // Register-enabled scan over pairs 0..2
    arm_host_inst.wr(ADDR_SEQ, 8'h21);
    for (int i = 0; i < 4; i++)
    begin
      conv();
      check("sw seq sel_a", sel_a, 4'(i % 3));
      check("sw seq sel_b", sel_b, 4'(i % 3));
    end
    arm_host_inst.rd(ADDR_STATUS, rd_val);
    check("status seq", rd_val, 8'h04);
    arm_host_inst.wr(ADDR_SEQ, 8'h00);
    $display("Software select test done");
    // Settle window on a pin change with filter option two
    range_pins = 2'h1;
    filter_option_two = 1'b1;
    cyc(30);
    range_pins = 2'h3;
    seen_cnt = 0;
    repeat (40)
    begin
      cyc(1);
      if (settle_pending === 1'b1)
        seen_cnt++;
    end
    check("settle", 16'(seen_cnt), 16'(SETTLE_SIM));
    check("range_a", range_a, 16'hFFFF);
    $display("Settle test done");
    // Reset in mid-run, hardware pins pick the first pair
    channel_pick_bus = 3'($urandom);
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(1);
    check("hw_mode", hw_mode, 1'b1);
    check("first sel_a", sel_a, {1'b0, channel_pick_bus});
    check("first sel_b", sel_b, {1'b0, channel_pick_bus});
    check("settle after reset", settle_pending, 1'b1);
    $display("Reset release test done");
    give_verdict();
  end

  // Watchdog against a hung sequence
  initial
  begin
    #100000;
    err_count++;
    $display("Watchdog expired");
    give_verdict();
  end
endmodule : arm_config_tb
